// *** hw/dbp_top.sv ***
// ddr2 burst read, burst write and precharge core with a small array
`timescale 1ns/1ns
`default_nettype none
// Function
// - read: chip select and column strobe low, row strobe and write enable high
// - first read data appears additive plus column access latency after the read
// - strobe is held low one clock before the first read beat
// - first read beat on rising strobe, later beats in phase with strobe
// - eight-beat reads every 4 clocks run gapless to any open bank
// - write: chip select, column strobe, write enable low, row strobe high
// - write latency is read latency minus one clock
// - write beats captured for a 4 or 8 beat burst, later data ignored
// - writes every half burst length clocks run gapless to any open bank
// - one mask bit per 8 data bits with write timing, unused on reads
// - precharge: chip select, row strobe, write enable low, column strobe high
// - precharge-all bit closes all banks, otherwise the selected bank only
// - burst_interleave_in picks nibble-wrapped sequential or interleaved order
module dbp_top
   import dbp_pkg::*;
#(
   parameter int DATA_W = DQ_W,
   parameter int CW     = COL_W,
   parameter int LAT_N  = MAX_LAT
) (
   input  wire logic                core_clk_in,
   input  wire logic                rst_b_in,
   input  wire logic                cs_b_in,
   input  wire logic                ras_b_in,
   input  wire logic                cas_b_in,
   input  wire logic                we_b_in,
   input  wire logic [ADDR_W-1:0]   addr_in,
   input  wire logic [BANK_W-1:0]   bank_sel_in,
   input  wire logic [2:0]          cas_latency_in,
   input  wire logic [2:0]          additive_latency_in,
   input  wire logic                burst_len8_in,
   input  wire logic                burst_interleave_in,
   input  wire logic [DATA_W-1:0]   wr_dq_rise_in,
   input  wire logic [DATA_W-1:0]   wr_dq_fall_in,
   input  wire logic [DATA_W/8-1:0] wr_data_mask_rise_in,
   input  wire logic [DATA_W/8-1:0] wr_data_mask_fall_in,
   output logic [DATA_W-1:0]        rd_dq_rise_out,
   output logic [DATA_W-1:0]        rd_dq_fall_out,
   output logic                     rd_valid_out,
   output logic                     dqs_preamble_out,
   output logic                     dqs_oe_out,
   output logic                     wr_burst_out,
   output logic [BANKS-1:0]         bank_open_out
);
   localparam int GRP = DATA_W / MASK_GRP;

   generate
      if (DATA_W % MASK_GRP != 0 || CW < 4 || CW > ADDR_W || LAT_N < 14) begin : g_chk
         $error("dbp_top: unsupported parameter set");
      end
   endgenerate

   logic [DATA_W-1:0]  mem [BANKS*(2**CW)];
   logic               cmd_rd, cmd_wr, cmd_pre, cmd_act;
   logic [LAT_W-1:0]   rl, wl, ins;
   logic [1:0]         last_pair;
   logic               slot_v_r [LAT_N];
   logic               slot_v_nxt [LAT_N];
   logic               slot_wr_r [LAT_N];
   logic               slot_wr_nxt [LAT_N];
   logic [BANK_W-1:0]  slot_bank_r [LAT_N];
   logic [BANK_W-1:0]  slot_bank_nxt [LAT_N];
   logic [CW-1:0]      slot_col_r [LAT_N];
   logic [CW-1:0]      slot_col_nxt [LAT_N];
   dbp_eng_t           st_r, st_nxt;
   logic [1:0]         cnt_r, cnt_nxt;
   logic [BANK_W-1:0]  eb_r, eb_nxt;
   logic [CW-1:0]      ec_r, ec_nxt;
   logic               sel_wr;
   logic [BANK_W-1:0]  src_bank;
   logic [1:0]         src_cnt;
   logic [CW+BANK_W-1:0] ia_rise, ia_fall;
   logic [DATA_W-1:0]  rd_rise_nxt, rd_fall_nxt;
   logic               rd_valid_nxt, pre_nxt, oe_nxt, wr_burst_nxt;
   logic [BANKS-1:0]   bank_open_r, bank_open_nxt;
   logic [LAT_N:0]     hist_rd_r, hist_wr_r;

   dbp_seq_if #(.COL_W(CW)) seq_rise ();
   dbp_seq_if #(.COL_W(CW)) seq_fall ();
   dbp_burst_seq #(.COL_W(CW)) u_seq_rise (.seq(seq_rise));
   dbp_burst_seq #(.COL_W(CW)) u_seq_fall (.seq(seq_fall));

   assign cmd_rd  = !cs_b_in && ras_b_in && !cas_b_in && we_b_in;
   assign cmd_wr  = !cs_b_in && ras_b_in && !cas_b_in && !we_b_in;
   assign cmd_pre = !cs_b_in && !ras_b_in && cas_b_in && !we_b_in;
   assign cmd_act = !cs_b_in && !ras_b_in && cas_b_in && we_b_in;
   assign rl = LAT_W'(additive_latency_in) + LAT_W'(cas_latency_in);
   assign wl = rl - 4'h1;
   // entry lands in slot 0 one clock before data, so the core sees a start one clock early
   assign ins = cmd_rd ? (rl - 4'h1) : (wl - 4'h1);
   assign last_pair = burst_len8_in ? LAST_PAIR_8 : LAST_PAIR_4;

   // delay line: a column command rides to slot 0 over its latency
   always_comb begin
      for (int i = 0; i < LAT_N; i++) begin
         if (i < LAT_N - 1) begin
            slot_v_nxt[i]    = slot_v_r[i+1];
            slot_wr_nxt[i]   = slot_wr_r[i+1];
            slot_bank_nxt[i] = slot_bank_r[i+1];
            slot_col_nxt[i]  = slot_col_r[i+1];
         end else begin
            slot_v_nxt[i]    = 1'b0;
            slot_wr_nxt[i]   = 1'b0;
            slot_bank_nxt[i] = '0;
            slot_col_nxt[i]  = '0;
         end
         if ((cmd_rd || cmd_wr) && int'(ins) == i) begin
            slot_v_nxt[i]    = 1'b1;
            slot_wr_nxt[i]   = cmd_wr;
            slot_bank_nxt[i] = bank_sel_in;
            slot_col_nxt[i]  = addr_in[CW-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < LAT_N; i++) begin
            slot_v_r[i]    <= 1'b0;
            slot_wr_r[i]   <= 1'b0;
            slot_bank_r[i] <= '0;
            slot_col_r[i]  <= '0;
         end
      end else begin
         slot_v_r    <= slot_v_nxt;
         slot_wr_r   <= slot_wr_nxt;
         slot_bank_r <= slot_bank_nxt;
         slot_col_r  <= slot_col_nxt;
      end
   end

   // a fresh start always reloads, which gives seamless and interrupted bursts alike
   always_comb begin
      st_nxt  = ENG_IDLE;
      cnt_nxt = PAIR_FIRST;
      eb_nxt  = eb_r;
      ec_nxt  = ec_r;
      if (slot_v_r[0]) begin
         st_nxt  = slot_wr_r[0] ? ENG_WRITE : ENG_READ;
         eb_nxt  = slot_bank_r[0];
         ec_nxt  = slot_col_r[0];
      end else if (st_r != ENG_IDLE && cnt_r != last_pair) begin
         st_nxt  = st_r;
         cnt_nxt = cnt_r + 2'h1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r  <= ENG_IDLE;
         cnt_r <= PAIR_FIRST;
         eb_r  <= '0;
         ec_r  <= '0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         eb_r  <= eb_nxt;
         ec_r  <= ec_nxt;
      end
   end

   // writes address the beat in flight, reads the beat about to be driven
   assign sel_wr   = (st_r == ENG_WRITE);
   assign src_bank = sel_wr ? eb_r : eb_nxt;
   assign src_cnt  = sel_wr ? cnt_r : cnt_nxt;
   assign seq_rise.start_col = sel_wr ? ec_r : ec_nxt;
   assign seq_fall.start_col = sel_wr ? ec_r : ec_nxt;
   assign seq_rise.beat = {src_cnt, 1'b0};
   assign seq_fall.beat = {src_cnt, 1'b1};
   assign seq_rise.ilv  = burst_interleave_in;
   assign seq_fall.ilv  = burst_interleave_in;
   assign ia_rise = {src_bank, seq_rise.col};
   assign ia_fall = {src_bank, seq_fall.col};

   // beats past the burst end never reach the array because the core is idle then
   always_ff @(posedge core_clk_in) begin
      if (st_r == ENG_WRITE) begin
         for (int g = 0; g < GRP; g++) begin
            if (!wr_data_mask_rise_in[g]) begin
               mem[ia_rise][g*MASK_GRP +: MASK_GRP] <=
                  wr_dq_rise_in[g*MASK_GRP +: MASK_GRP];
            end
            if (!wr_data_mask_fall_in[g]) begin
               mem[ia_fall][g*MASK_GRP +: MASK_GRP] <=
                  wr_dq_fall_in[g*MASK_GRP +: MASK_GRP];
            end
         end
      end
   end

   always_comb begin
      rd_valid_nxt = (st_nxt == ENG_READ);
      rd_rise_nxt  = rd_valid_nxt ? mem[ia_rise] : '0;
      rd_fall_nxt  = rd_valid_nxt ? mem[ia_fall] : '0;
      // no preamble when a read burst carries on seamlessly
      pre_nxt      = slot_v_r[1] && !slot_wr_r[1] && !rd_valid_nxt;
      oe_nxt       = pre_nxt || rd_valid_nxt;
      wr_burst_nxt = (st_nxt == ENG_WRITE);
      bank_open_nxt = bank_open_r;
      if (cmd_act) begin
         bank_open_nxt[bank_sel_in] = 1'b1;
      end else if (cmd_pre && addr_in[PRECHARGE_ALL_BIT]) begin
         bank_open_nxt = BANKS_CLOSED;
      end else if (cmd_pre) begin
         bank_open_nxt[bank_sel_in] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_dq_rise_out   <= '0;
         rd_dq_fall_out   <= '0;
         rd_valid_out     <= 1'b0;
         dqs_preamble_out <= 1'b0;
         dqs_oe_out       <= 1'b0;
         wr_burst_out     <= 1'b0;
         bank_open_r      <= BANKS_CLOSED;
         hist_rd_r        <= '0;
         hist_wr_r        <= '0;
      end else begin
         rd_dq_rise_out   <= rd_rise_nxt;
         rd_dq_fall_out   <= rd_fall_nxt;
         rd_valid_out     <= rd_valid_nxt;
         dqs_preamble_out <= pre_nxt;
         dqs_oe_out       <= oe_nxt;
         wr_burst_out     <= wr_burst_nxt;
         bank_open_r      <= bank_open_nxt;
         hist_rd_r        <= {hist_rd_r[LAT_N-1:0], cmd_rd};
         hist_wr_r        <= {hist_wr_r[LAT_N-1:0], cmd_wr};
      end
   end
   assign bank_open_out = bank_open_r;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   chk_rd_latency: assert property ($rose(rd_valid_out) |-> hist_rd_r[rl])
      else $error("read data not at read latency");
   chk_rd_preamble: assert property ($rose(rd_valid_out) |-> $past(dqs_preamble_out))
      else $error("read burst without strobe preamble");
   chk_strobe_data: assert property (dqs_preamble_out |=> rd_valid_out && dqs_oe_out)
      else $error("preamble not followed by driven strobe and data");
   chk_wr_latency: assert property ($rose(wr_burst_out) |-> hist_wr_r[wl])
      else $error("write capture not at write latency");
   chk_wr_burst_end: assert property (wr_burst_out && cnt_r == last_pair && !slot_v_r[0]
                                      |=> !wr_burst_out)
      else $error("write capture runs past burst end");
   chk_burst_length: assert property ($rose(st_r != ENG_IDLE) && burst_len8_in
                                      |-> (st_r != ENG_IDLE) [*4])
      else $error("eight beat burst cut short");
   chk_burst_reload: assert property (slot_v_r[0]
                                      |=> st_r != ENG_IDLE && cnt_r == PAIR_FIRST)
      else $error("column start not taken");
   chk_pre_all: assert property (cmd_pre && addr_in[PRECHARGE_ALL_BIT]
                                 |=> bank_open_out == BANKS_CLOSED)
      else $error("precharge all left a bank open");
   chk_pre_single: assert property (cmd_pre && !addr_in[PRECHARGE_ALL_BIT]
                                    |=> !bank_open_out[$past(bank_sel_in)] &&
                                    $countones(bank_open_out ^ $past(bank_open_out)) <= 1)
      else $error("single bank precharge closed the wrong banks");

   cov_read_seamless: cover property ($rose(rd_valid_out) ##0 rd_valid_out [*8]);
   cov_write_burst: cover property ($rose(wr_burst_out) ##0 wr_burst_out [*2]);
   cov_interrupt: cover property (slot_v_r[0] && st_r != ENG_IDLE && cnt_r == 2'h1
                                  && burst_len8_in);
   cov_pre_all: cover property (cmd_pre && addr_in[PRECHARGE_ALL_BIT]
                                && bank_open_out != BANKS_CLOSED);
endmodule : dbp_top
`default_nettype wire

// *** inc/dbp_pkg.sv ***
// shared constants and types for the ddr2 column and precharge logic
package dbp_pkg;
   localparam int          BANKS             = 4;
   localparam int          BANK_W            = 2;
   localparam int          ADDR_W            = 14;
   localparam int          COL_W             = 10;
   localparam int          DQ_W              = 8;
   localparam int          MASK_GRP          = 8;
   localparam int          LAT_W             = 4;
   localparam int          MAX_LAT           = 16;
   localparam int          PRECHARGE_ALL_BIT = 10;
   localparam logic [1:0]  LAST_PAIR_4       = 2'h1;
   localparam logic [1:0]  LAST_PAIR_8       = 2'h3;
   localparam logic [1:0]  PAIR_FIRST        = 2'h0;
   localparam logic [3:0]  BANKS_CLOSED      = 4'h0;

   typedef enum logic [2:0] {
      ENG_IDLE  = 3'h1,
      ENG_READ  = 3'h2,
      ENG_WRITE = 3'h4
   } dbp_eng_t;
endpackage : dbp_pkg

// *** inc/dbp_seq_if.sv ***
// burst ordering request and answer between the core and the sequencer
`timescale 1ns/1ns
`default_nettype none
interface dbp_seq_if #(parameter int COL_W = 10);
   logic [COL_W-1:0] start_col;
   logic [2:0]       beat;
   logic             ilv;
   logic [COL_W-1:0] col;
   modport calc (input start_col, input beat, input ilv, output col);
   modport user (output start_col, output beat, output ilv, input col);
endinterface : dbp_seq_if
`default_nettype wire

// *** hw/dbp_burst_seq.sv ***
// column of one burst beat from start column, beat index and burst type
`timescale 1ns/1ns
`default_nettype none
module dbp_burst_seq
   import dbp_pkg::*;
#(
   parameter int COL_W = 10
) (
   dbp_seq_if.calc seq
);
   logic [2:0] low;

   generate
      if (COL_W < 4) begin : g_chk
         $error("dbp_burst_seq: COL_W too small");
      end
   endgenerate

   // four-beat bursts never set beat bit 2, so both orders stay inside the nibble
   always_comb begin
      if (seq.ilv) begin
         low = seq.start_col[2:0] ^ seq.beat;
      end else begin
         low = {seq.start_col[2] ^ seq.beat[2],
                2'(seq.start_col[1:0] + seq.beat[1:0])};
      end
      seq.col = {seq.start_col[COL_W-1:3], low};
   end
endmodule : dbp_burst_seq
`default_nettype wire

// *** sim/dbp_ctrl_model.sv ***
// controller-side model: command pins, command spacing and write data
`timescale 1ns/1ns
`default_nettype none
module dbp_ctrl_model
   import dbp_pkg::*;
#(
   parameter int WRITE_TO_READ_GAP = 2,
   parameter int READ_TO_PRECHARGE_TIME = 2,
   parameter int STORE_RECOVERY_TIME  = 3
) (
   input  wire logic              clk_in,
   input  wire logic [2:0]        cl_in,
   input  wire logic [2:0]        al_in,
   input  wire logic              bl8_in,
   output logic      [3:0]        cmd_out,
   output logic      [ADDR_W-1:0] addr_out,
   output logic      [BANK_W-1:0] bank_out,
   output logic      [DQ_W-1:0]   dr_out,
   output logic      [DQ_W-1:0]   df_out,
   output logic      [1:0]        dm_out
);
   int cyc = 0;
   int last_rd = -99;
   int last_wr = -99;
   initial begin
      cmd_out = 4'h7;
      addr_out = '0;
      bank_out = '0;
      {dr_out, df_out} = 16'h5AA5;
      dm_out = 2'h0;
   end
   task automatic step(input logic [3:0] k, input logic [ADDR_W-1:0] a,
                       input logic [BANK_W-1:0] b, input bit drv, input logic [15:0] d,
                       input logic [1:0] m);
      @(posedge clk_in);
      #1;
      cyc++;
      cmd_out = k;
      addr_out = a;
      bank_out = b;
      // released lines show the inverse so stale data never passes as written
      {dr_out, df_out} = drv ? d : ~{dr_out, df_out};
      dm_out = drv ? m : ~dm_out;
   endtask : step
   // read after read and write after write need only 2 clocks, so four-beat bursts stay whole but eight-beat ones can be cut short
   task automatic cmd(input logic [3:0] k, input logic [ADDR_W-1:0] a,
                      input logic [BANK_W-1:0] b);
      int bh;
      int cl;
      int al;
      int need;
      bh = bl8_in ? 4 : 2;
      cl = int'(cl_in);
      al = int'(al_in);
      need = 0;
      if (k == 4'h5 || k == 4'h4) begin
         need = ((last_rd > last_wr) ? last_rd : last_wr) + 2;
      end
      if (k == 4'h4 && last_rd + bh + 2 > need) need = last_rd + bh + 2;
      if (k == 4'h5 && last_wr + cl - 1 + bh + WRITE_TO_READ_GAP > need) begin
         need = last_wr + cl - 1 + bh + WRITE_TO_READ_GAP;
      end
      // read_to_precharge_time is kept at 2 or more, so the max term is read_to_precharge_time itself
      if (k == 4'h2) need = last_rd + al + bh + READ_TO_PRECHARGE_TIME - 2;
      if (k == 4'h2 && last_wr + al + cl - 1 + bh + STORE_RECOVERY_TIME > need) begin
         need = last_wr + al + cl - 1 + bh + STORE_RECOVERY_TIME;
      end
      while (cyc + 1 < need) step(4'h7, '0, '0, 1'b0, '0, 2'h0);
      step(k, a, b, 1'b0, '0, 2'h0);
      if (k == 4'h5) last_rd = cyc;
      if (k == 4'h4) last_wr = cyc;
   endtask : cmd
   task automatic dat(input bit drv, input logic [15:0] d, input logic [1:0] m);
      step(4'h7, '0, '0, drv, d, m);
   endtask : dat
endmodule : dbp_ctrl_model
`default_nettype wire

// *** sim/dbp_top_tb.sv ***
// self-checking bench for the ddr2 column and precharge core
`timescale 1ns/1ns
`default_nettype none
module dbp_top_tb;
   import dbp_pkg::*;
   logic             clk;
   logic             rst_b;
   logic [2:0]       cl;
   logic [2:0]       al;
   logic             bl8;
   logic             ilv;
   logic [3:0]       cmd;
   logic [ADDR_W-1:0] addr;
   logic [BANK_W-1:0] bank;
   logic [7:0]       dr;
   logic [7:0]       df;
   logic [1:0]       dm;
   logic [7:0]       rq_r;
   logic [7:0]       rq_f;
   logic             rv;
   logic             pre;
   logic             oe;
   logic             wb;
   logic [3:0]       bo;
   logic [7:0]       shadow [0:15];
   int               err_total = 0;
   int               checked = 0;
   dbp_ctrl_model u_dbp_ctrl_model (.clk_in(clk), .cl_in(cl), .al_in(al), .bl8_in(bl8),
      .cmd_out(cmd), .addr_out(addr), .bank_out(bank), .dr_out(dr), .df_out(df), .dm_out(dm));
   dbp_top u_dbp_top (.core_clk_in(clk), .rst_b_in(rst_b), .cs_b_in(cmd[3]), .ras_b_in(cmd[2]),
      .cas_b_in(cmd[1]), .we_b_in(cmd[0]), .addr_in(addr), .bank_sel_in(bank),
      .cas_latency_in(cl), .additive_latency_in(al), .burst_len8_in(bl8),
      .burst_interleave_in(ilv), .wr_dq_rise_in(dr), .wr_dq_fall_in(df),
      .wr_data_mask_rise_in(dm[0]), .wr_data_mask_fall_in(dm[1]), .rd_dq_rise_out(rq_r),
      .rd_dq_fall_out(rq_f), .rd_valid_out(rv), .dqs_preamble_out(pre), .dqs_oe_out(oe),
      .wr_burst_out(wb), .bank_open_out(bo));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   function automatic int col(input int s, input int i);
      int m;
      m = bl8 ? 7 : 3;
      if (ilv) return (s & ~m) | ((s ^ i) & m);
      return (s & ~m) | (((s & 3) + i) & 3) | ((s ^ i) & m & 4);
   endfunction : col
   // start column is kept burst aligned here, so beat n lands on column c+n
   task automatic wr(input int c, input logic [7:0] base, input int mb);
      int wl;
      int h;
      logic [7:0] v0;
      logic [7:0] v1;
      wl = int'(al) + int'(cl) - 1;
      h = bl8 ? 4 : 2;
      u_dbp_ctrl_model.cmd(4'h4, 14'(c), 2'h0);
      for (int k = 0; k <= wl + h; k++) begin
         v0 = 8'(int'(base) + 2 * (k - wl));
         v1 = v0 + 8'h01;
         if (k >= wl && k < wl + h) begin
            u_dbp_ctrl_model.dat(1'b1, {v0, v1}, {2 * (k - wl) + 1 == mb, 2 * (k - wl) == mb});
            if (2 * (k - wl) != mb) shadow[c + 2 * (k - wl)] = v0;
            if (2 * (k - wl) + 1 != mb) shadow[c + 2 * (k - wl) + 1] = v1;
         end else u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
         chk({7'h00, wb}, {7'h00, (k >= wl && k < wl + h)});
      end
   endtask : wr
   task automatic rd(input int c);
      int rl;
      int h;
      int j;
      rl = int'(al) + int'(cl);
      h = bl8 ? 4 : 2;
      u_dbp_ctrl_model.cmd(4'h5, 14'(c), 2'h0);
      for (int k = 0; k <= rl + h; k++) begin
         u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
         j = k - rl;
         chk({7'h00, pre}, {7'h00, (k == rl - 1)});
         chk({7'h00, rv}, {7'h00, (j >= 0 && j < h)});
         chk({7'h00, oe}, {7'h00, (k >= rl - 1 && j < h)});
         chk(rq_r, (j >= 0 && j < h) ? shadow[col(c, 2 * j)] : 8'h00);
         chk(rq_f, (j >= 0 && j < h) ? shadow[col(c, 2 * j + 1)] : 8'h00);
      end
   endtask : rd
   // second read four clocks after the first, so its data must follow with no gap or preamble
   task automatic t_seam();
      int rl;
      int j;
      rl = int'(al) + int'(cl);
      ilv = 1'b0;
      u_dbp_ctrl_model.cmd(4'h5, 14'h0008, 2'h0);
      for (int k = 0; k <= rl + 8; k++) begin
         if (k == 3) u_dbp_ctrl_model.cmd(4'h5, 14'h000C, 2'h0);
         else u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
         j = k - rl;
         chk({7'h00, pre}, {7'h00, (k == rl - 1)});
         chk({7'h00, rv}, {7'h00, (j >= 0 && j < 8)});
         chk({7'h00, oe}, {7'h00, (k >= rl - 1 && j < 8)});
         chk(rq_r, (j >= 0 && j < 8) ? shadow[col(j < 4 ? 8 : 12, 2 * (j % 4))] : 8'h00);
         chk(rq_f, (j >= 0 && j < 8) ? shadow[col(j < 4 ? 8 : 12, 2 * (j % 4) + 1)] : 8'h00);
      end
      $display("seamless read test done");
   endtask : t_seam
   task automatic t_bank();
      for (int b = 0; b < 4; b++) u_dbp_ctrl_model.cmd(4'h3, 14'h0000, 2'(b));
      u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
      chk({4'h0, bo}, 8'h0F);
      u_dbp_ctrl_model.cmd(4'h2, 14'h0000, 2'h2);
      u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
      chk({4'h0, bo}, 8'h0B);
      u_dbp_ctrl_model.cmd(4'h2, 14'h0400, 2'h1);
      u_dbp_ctrl_model.dat(1'b0, '0, 2'h0);
      chk({4'h0, bo}, 8'h00);
      $display("bank test done");
   endtask : t_bank
   task automatic t_bl4();
      u_dbp_ctrl_model.cmd(4'h3, 14'h0000, 2'h0);
      wr(0, 8'h10, 99);
      wr(0, 8'h20, 2);
      rd(1);
      ilv = 1'b1;
      rd(1);
      $display("four beat test done");
   endtask : t_bl4
   task automatic t_bl8();
      al = 3'h2;
      bl8 = 1'b1;
      ilv = 1'b0;
      wr(8, 8'h30, 99);
      wr(8, 8'h40, 5);
      rd(13);
      ilv = 1'b1;
      rd(13);
      $display("eight beat test done");
   endtask : t_bl8
   initial begin
      rst_b = 1'b0;
      cl = 3'h5;
      al = 3'h0;
      bl8 = 1'b0;
      ilv = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      chk({pre, oe, bo, rv, wb}, 8'h00);
      t_bank();
      t_bl4();
      t_bl8();
      t_seam();
      conclude();
   end
   // the whole sequence is well under two hundred clocks, so this limit only trips on a hang
   initial begin
      #20000;
      err_total++;
      conclude();
   end
endmodule : dbp_top_tb
`default_nettype wire
